// ### core/gpm_map.svh
// register map, field positions and reset values of the gpio port block
// assumes a 32-bit apb slave, one register per aligned word
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH
// pin multiplexer register indices, byte address is index * 4
`define GPM_IDX_EVOUT 10'h000
`define GPM_IDX_SERIAL 10'h001
`define GPM_IDX_TIMER 10'h002
// port register windows, as word indices
`define GPM_PORT_BASE 10'h020
`define GPM_PORT_SPAN 10'h040
`define GPM_ALIAS_BASE 10'h080
`define GPM_ALIAS_SPAN 10'h008
// pin multiplexer fields and writable masks
`define GPM_EVENT_OUT0_BIT 0
`define GPM_EVENT_OUT1_BIT 1
`define GPM_SERIAL_BIT 0
`define GPM_SPI_BIT 2
`define GPM_TIMER_BIT 0
`define GPM_EVOUT_MASK 8'h03
`define GPM_SERIAL_MASK 8'h05
`define GPM_TIMER_MASK 8'h01
// pin configuration fields
`define GPM_PULLUP_BIT 3
`define GPM_INVERT_BIT 7
// reset values
`define GPM_MUX_RESET 8'h00
`define GPM_PORT_RESET 8'h00
`endif

// ### core/gpm_pkg.sv
// types shared by the gpio port block
// assumes gpm_map.svh supplies the numeric constants
package gpm_pkg;
    typedef enum logic [2:0] {
        SENSE_OFF = 3'h0,
        SENSE_BOTH = 3'h1,
        SENSE_RISE = 3'h2,
        SENSE_FALL = 3'h3,
        SENSE_INPUT_OFF = 3'h4,
        SENSE_LOW = 3'h5
    } gpm_sense_type;

    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_DIR = 4'h1,
        K_DIRSET = 4'h2,
        K_DIRCLR = 4'h3,
        K_DIRTGL = 4'h4,
        K_OUT = 4'h5,
        K_OUTSET = 4'h6,
        K_OUTCLR = 4'h7,
        K_OUTTGL = 4'h8,
        K_IN = 4'h9,
        K_FLAGS = 4'ha,
        K_PINCFG = 4'hb
    } gpm_kind_type;

    typedef struct packed {
        logic hit;
        logic is_mux;
        logic [1:0] mux_sel;
        logic port;
        gpm_kind_type kind;
        logic [2:0] pin;
    } gpm_dec_type;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] oe;
        logic [7:0] pull;
    } gpm_pad_type;
endpackage

// ### core/gpm_top.sv
// two 8-pin gpio ports with pin multiplexer, apb register access
// assumes pads resolve drive/oe/pull, pins asynchronous to ref_clk
`timescale 1ns/1ps
`include "gpm_map.svh"

// Overview of operation
// - per-pin direction and output value bits
// - input value passes a clocked synchronizer
// - input-disabled pins stop their synchronizer
// - pin level readable in any direction
// - edge and low-level sensing raises flags
// - asynchronous pin sensing wakes without clock
// - set, clear, toggle registers change only ones
// - direction change leaves other pins untouched
// - per-pin inversion and pull-up enable
// - alias registers behave as regular ones
// - two independent port instances
// - debug has no effect, events reach router
// - event output enable bits one and zero
// - bit 2 moves spi to alternative pins
// - bit 0 moves serial to alternative pins
// - bit 0 moves timer wave 0 pin
// - split mode routes low compare channel 0
// - reset leaves pads tri-stated, inputs enabled
// - set, clear, toggle or input write on output
// - event equals level, zero when input disabled
module gpm_top
    import gpm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pads, one group of eight per port
    input wire logic [1:0][7:0] pin_in,
    output gpm_pad_type [1:0] pad_ctrl,
    output logic wake_async,
    output logic [1:0] port_irq,
    // events
    output logic [1:0][7:0] pin_event,
    input wire logic [1:0] evout_src,
    output logic [1:0] evout_pin,
    output logic [1:0] evout_oe,
    // peripheral routing
    input wire logic timer_wave0,
    input wire logic timer_split,
    input wire logic timer_low_cmp0,
    output logic wave0_default_pin,
    output logic wave0_alt_pin,
    output logic spi_alt_route,
    output logic serial_alt_route
);

    function automatic gpm_dec_type dec_addr(input logic [9:0] idx);
        gpm_dec_type d;
        logic [9:0] off;
        d = '0;
        d.kind = K_NONE;
        off = idx - `GPM_PORT_BASE;
        if (idx <= `GPM_IDX_TIMER)
        begin
            d.hit = 1'b1;
            d.is_mux = 1'b1;
            d.mux_sel = idx[1:0];
        end
        else if (off < `GPM_PORT_SPAN)
        begin
            d.port = off[5];
            d.pin = off[2:0];
            if (off[4] && !off[3])
            begin
                d.hit = 1'b1;
                d.kind = K_PINCFG;
            end
            else if (!off[4] && off[3:0] <= 4'h9)
            begin
                d.hit = 1'b1;
                d.kind = gpm_kind_type'(off[3:0] + 4'h1);
            end
        end
        else if (idx - `GPM_ALIAS_BASE < `GPM_ALIAS_SPAN)
        begin
            off = idx - `GPM_ALIAS_BASE;
            d.hit = 1'b1;
            d.port = off[2];
            case (off[1:0])
                2'h0: d.kind = K_DIR;
                2'h1: d.kind = K_OUT;
                2'h2: d.kind = K_IN;
                default: d.kind = K_FLAGS;
            endcase
        end
        return d;
    endfunction

    // port state, one set per instance
    logic [7:0] dir_reg [2], dir_next [2];
    logic [7:0] out_reg [2], out_next [2];
    logic [7:0] flags_reg [2], flags_next [2];
    logic [7:0] sync1_reg [2], sync1_next [2];
    logic [7:0] sync2_reg [2], sync2_next [2];
    logic [7:0] prev_reg [2], prev_next [2];
    logic [7:0] cfg_reg [2][8], cfg_next [2][8];
    logic [7:0] evout_reg, evout_next;
    logic [7:0] serial_reg, serial_next;
    logic [7:0] timer_reg, timer_next;
    // per-pin derived levels
    logic [7:0] en [2], inv [2], lv [2], sense [2], wake_pin [2];
    // registered outputs
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    gpm_pad_type [1:0] pad_next;
    logic [1:0][7:0] event_next;
    logic [1:0] irq_next, evpin_next, evoe_next;
    logic w0d_next, w0a_next, spi_next, ser_next, w0_src;
    gpm_dec_type dec;
    logic wr;
    logic [7:0] wd;

    assign dec = dec_addr(paddr[11:2]);
    assign wr = psel && penable && pready && pwrite;
    assign wd = pwdata[7:0];

    // pin sensing; debug state has no input here, so nothing changes
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            for (int n = 0; n < 8; n++)
            begin
                gpm_sense_type mode;
                logic lvl, now;
                mode = gpm_sense_type'(cfg_reg[p][n][2:0]);
                en[p][n] = mode != SENSE_INPUT_OFF;
                inv[p][n] = cfg_reg[p][n][`GPM_INVERT_BIT];
                lvl = sync2_reg[p][n] ^ inv[p][n];
                lv[p][n] = lvl;
                case (mode)
                    SENSE_BOTH: sense[p][n] = lvl != prev_reg[p][n];
                    SENSE_RISE: sense[p][n] = lvl && !prev_reg[p][n];
                    SENSE_FALL: sense[p][n] = !lvl && prev_reg[p][n];
                    SENSE_LOW: sense[p][n] = !lvl;
                    default: sense[p][n] = 1'b0;
                endcase
                // raw pin compare, works with the clock stopped
                now = pin_in[p][n] ^ inv[p][n];
                case (mode)
                    SENSE_BOTH: wake_pin[p][n] = now != lvl;
                    SENSE_RISE: wake_pin[p][n] = now && !lvl;
                    SENSE_FALL: wake_pin[p][n] = !now && lvl;
                    SENSE_LOW: wake_pin[p][n] = !now;
                    default: wake_pin[p][n] = 1'b0;
                endcase
            end
        end
    end

    // unclocked path on purpose: a stopped clock must still wake
    assign wake_async = |{wake_pin[0], wake_pin[1]};

    always_comb
    begin
        evout_next = evout_reg;
        serial_next = serial_reg;
        timer_next = timer_reg;
        if (wr && dec.is_mux)
        begin
            case (dec.mux_sel)
                2'h0: evout_next = wd & `GPM_EVOUT_MASK;
                2'h1: serial_next = wd & `GPM_SERIAL_MASK;
                2'h2: timer_next = wd & `GPM_TIMER_MASK;
                default: ;
            endcase
        end
        for (int p = 0; p < 2; p++)
        begin
            logic sel;
            sel = wr && dec.hit && !dec.is_mux && (dec.port == p[0]);
            dir_next[p] = dir_reg[p];
            out_next[p] = out_reg[p];
            cfg_next[p] = cfg_reg[p];
            // a gated synchronizer holds instead of toggling
            sync1_next[p] = (pin_in[p] & en[p]) | (sync1_reg[p] & ~en[p]);
            sync2_next[p] = (sync1_reg[p] & en[p]) | (sync2_reg[p] & ~en[p]);
            prev_next[p] = lv[p];
            // a new event beats a clear in the same cycle
            flags_next[p] = flags_reg[p] | (sense[p] & en[p]);
            if (sel)
            begin
                case (dec.kind)
                    K_DIR: dir_next[p] = wd;
                    K_DIRSET: dir_next[p] = dir_reg[p] | wd;
                    K_DIRCLR: dir_next[p] = dir_reg[p] & ~wd;
                    K_DIRTGL: dir_next[p] = dir_reg[p] ^ wd;
                    K_OUT: out_next[p] = wd;
                    K_OUTSET: out_next[p] = out_reg[p] | wd;
                    K_OUTCLR: out_next[p] = out_reg[p] & ~wd;
                    K_OUTTGL, K_IN: out_next[p] = out_reg[p] ^ wd;
                    K_FLAGS: flags_next[p] = (flags_reg[p] & ~wd)
                        | (sense[p] & en[p]);
                    K_PINCFG: cfg_next[p][dec.pin] = wd;
                    default: ;
                endcase
            end
        end
    end

    always_comb
    begin
        prdata_next = 32'h0000_0000;
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !dec.hit;
        if (dec.is_mux)
        begin
            case (dec.mux_sel)
                2'h0: prdata_next[7:0] = evout_reg;
                2'h1: prdata_next[7:0] = serial_reg;
                2'h2: prdata_next[7:0] = timer_reg;
                default: ;
            endcase
        end
        else
        begin
            case (dec.kind)
                K_DIR, K_DIRSET, K_DIRCLR, K_DIRTGL:
                    prdata_next[7:0] = dir_reg[dec.port];
                K_OUT, K_OUTSET, K_OUTCLR, K_OUTTGL:
                    prdata_next[7:0] = out_reg[dec.port];
                // level read regardless of direction
                K_IN: prdata_next[7:0] = lv[dec.port] & en[dec.port];
                K_FLAGS: prdata_next[7:0] = flags_reg[dec.port];
                K_PINCFG: prdata_next[7:0] = cfg_reg[dec.port][dec.pin];
                default: ;
            endcase
        end
        for (int p = 0; p < 2; p++)
        begin
            for (int n = 0; n < 8; n++)
            begin
                pad_next[p].pull[n] = cfg_reg[p][n][`GPM_PULLUP_BIT];
            end
            pad_next[p].drive = out_reg[p] ^ inv[p];
            pad_next[p].oe = dir_reg[p];
            event_next[p] = lv[p] & en[p];
            irq_next[p] = |flags_reg[p];
        end
        evoe_next = evout_reg[1:0];
        evpin_next = evout_src & evout_reg[1:0];
        // split mode swaps in the low-byte compare 0 waveform
        w0_src = timer_split ? timer_low_cmp0 : timer_wave0;
        w0a_next = timer_reg[`GPM_TIMER_BIT] && w0_src;
        w0d_next = !timer_reg[`GPM_TIMER_BIT] && w0_src;
        spi_next = serial_reg[`GPM_SPI_BIT];
        ser_next = serial_reg[`GPM_SERIAL_BIT];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int p = 0; p < 2; p++)
            begin
                dir_reg[p] <= `GPM_PORT_RESET;
                out_reg[p] <= `GPM_PORT_RESET;
                flags_reg[p] <= `GPM_PORT_RESET;
                sync1_reg[p] <= `GPM_PORT_RESET;
                sync2_reg[p] <= `GPM_PORT_RESET;
                prev_reg[p] <= `GPM_PORT_RESET;
                for (int n = 0; n < 8; n++)
                begin
                    cfg_reg[p][n] <= `GPM_PORT_RESET;
                end
            end
            evout_reg <= `GPM_MUX_RESET;
            serial_reg <= `GPM_MUX_RESET;
            timer_reg <= `GPM_MUX_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pad_ctrl <= '0;
            pin_event <= '0;
            port_irq <= 2'h0;
            evout_pin <= 2'h0;
            evout_oe <= 2'h0;
            wave0_default_pin <= 1'b0;
            wave0_alt_pin <= 1'b0;
            spi_alt_route <= 1'b0;
            serial_alt_route <= 1'b0;
        end
        else
        begin
            dir_reg <= dir_next;
            out_reg <= out_next;
            flags_reg <= flags_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
            cfg_reg <= cfg_next;
            evout_reg <= evout_next;
            serial_reg <= serial_next;
            timer_reg <= timer_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            pad_ctrl <= pad_next;
            pin_event <= event_next;
            port_irq <= irq_next;
            evout_pin <= evpin_next;
            evout_oe <= evoe_next;
            wave0_default_pin <= w0d_next;
            wave0_alt_pin <= w0a_next;
            spi_alt_route <= spi_next;
            serial_alt_route <= ser_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_wr(gpm_kind_type k);
        wr && dec.hit && !dec.is_mux && !dec.port && dec.kind == k;
    endsequence

    property p_dir_set;
        logic [7:0] d, w;
        (s_wr(K_DIRSET), d = dir_reg[0], w = wd) |=> dir_reg[0] == (d | w);
    endproperty
    a_dir_set: assert property (p_dir_set)
        else $error("direction set write wrong");

    property p_dir_clr;
        logic [7:0] d, w;
        (s_wr(K_DIRCLR), d = dir_reg[0], w = wd) |=> dir_reg[0] == (d & ~w);
    endproperty
    a_dir_clr: assert property (p_dir_clr)
        else $error("direction clear disturbed other pins");

    property p_in_toggle;
        logic [7:0] o, w;
        (s_wr(K_IN), o = out_reg[0], w = wd) |=> out_reg[0] == (o ^ w);
    endproperty
    a_in_toggle: assert property (p_in_toggle)
        else $error("input write did not toggle output");

    property p_sync_gate;
        !en[0][0] && $stable(cfg_reg[0][0]) |=> $stable(sync2_reg[0][0]);
    endproperty
    a_sync_gate: assert property (p_sync_gate)
        else $error("disabled synchronizer moved");

    sequence s_pin_steady;
        (en[0][0] && $stable(pin_in[0][0])) [*3];
    endsequence
    property p_sync_lat;
        s_pin_steady |-> sync2_reg[0][0] == pin_in[0][0];
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("synchronizer did not follow pin in two cycles");

    property p_rise_flag;
        cfg_reg[0][3][2:0] == SENSE_RISE && lv[0][3] && !prev_reg[0][3]
            |=> flags_reg[0][3] ##1 port_irq[0];
    endproperty
    a_rise_flag: assert property (p_rise_flag)
        else $error("rising edge did not raise flag and interrupt");

    property p_evt_zero;
        !en[0][0] |=> pin_event[0][0] == 1'b0;
    endproperty
    a_evt_zero: assert property (p_evt_zero)
        else $error("event active while input disabled");

    property p_mux_mask;
        (evout_reg & ~`GPM_EVOUT_MASK) == 8'h00
            && (serial_reg & ~`GPM_SERIAL_MASK) == 8'h00
            && (timer_reg & ~`GPM_TIMER_MASK) == 8'h00;
    endproperty
    a_mux_mask: assert property (p_mux_mask)
        else $error("reserved multiplexer bit set");

    property p_route_spi;
        wr && dec.is_mux && dec.mux_sel == 2'h1
            |=> ##1 spi_alt_route == $past(wd[`GPM_SPI_BIT], 2);
    endproperty
    a_route_spi: assert property (p_route_spi)
        else $error("spi route did not follow write");

endmodule // gpm_top

// ### dv/gpm_pad_model.sv
// pad model: resolves each pin from the block's pad controls
// assumes the outside source is weak, so a driven pad or pull-up wins
`timescale 1ns/1ps
module gpm_pad_model
    import gpm_pkg::*;
(
    // block side
    input wire gpm_pad_type [1:0] pad_ctrl,
    // outside source and resolved level
    input wire logic [1:0][7:0] ext_level,
    output logic [1:0][7:0] pin_level
);
    always_comb
    begin
        for (int p = 0; p < 2; p++)
            for (int n = 0; n < 8; n++)
                if (pad_ctrl[p].oe[n])
                    pin_level[p][n] = pad_ctrl[p].drive[n];
                else if (pad_ctrl[p].pull[n])
                    pin_level[p][n] = 1'b1;
                else
                    pin_level[p][n] = ext_level[p][n];
    end
endmodule // gpm_pad_model

// ### dv/gpio_port_with_pin_mux_tb_top.sv
// self-checking bench of the gpio port block over apb
// assumes a zero-wait-state apb slave and pads resolved by gpm_pad_model
`timescale 1ns/1ps
module gpio_port_with_pin_mux_tb_top
    import gpm_pkg::*;
;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0, ia;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h0000_2ce8;
    logic pready, pslverr, er, wake_async;
    logic [1:0][7:0] pin_in, ext = '0, pin_event;
    gpm_pad_type [1:0] pad_ctrl;
    logic [1:0] port_irq, evout_src = '0, evout_pin, evout_oe;
    logic timer_wave0 = 0, timer_split = 0, timer_low_cmp0 = 0;
    logic wave0_default_pin, wave0_alt_pin, spi_alt_route, serial_alt_route;
    logic [7:0] ed [2], eo [2], mx [3], d, src;
    logic [7:0] msk [3] = '{8'h03, 8'h05, 8'h01};
    gpm_sense_type md [4] = '{SENSE_BOTH, SENSE_RISE, SENSE_FALL, SENSE_LOW};
    int errors = 0, checks = 0;

    always #20 ref_clk = ~ref_clk;

    gpm_pad_model pad_u (.pad_ctrl(pad_ctrl), .ext_level(ext),
        .pin_level(pin_in));
    gpm_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pad_ctrl(pad_ctrl), .wake_async(wake_async),
        .port_irq(port_irq), .pin_event(pin_event), .evout_src(evout_src),
        .evout_pin(evout_pin), .evout_oe(evout_oe),
        .timer_wave0(timer_wave0), .timer_split(timer_split),
        .timer_low_cmp0(timer_low_cmp0),
        .wave0_default_pin(wave0_default_pin), .wave0_alt_pin(wave0_alt_pin),
        .spi_alt_route(spi_alt_route), .serial_alt_route(serial_alt_route));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // pin level seen by the port: driven bits from out, others from outside
    function automatic logic [7:0] lvl(input int p);
        return (eo[p] & ed[p]) | (ext[p] & ~ed[p]);
    endfunction

    function automatic logic [11:0] pb(input int p);
        return p ? 12'h100 : 12'h080;
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one apb transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] dt);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, dt};
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("[FAIL] %0t apb answer timed out", $time);
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] dt);
        apb(1'b1, a, dt);
    endtask

    task automatic rdck(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, exp});
    endtask

    initial
    begin
        for (int p = 0; p < 2; p++)
        begin
            ed[p] = 8'h00;
            eo[p] = 8'h00;
        end
        tick(3);
        resetn <= 1;
        for (int i = 0; i < 3; i++)
            rdck(12'(i * 4), 8'h00);
        rdck(12'h080, 8'h00);
        rdck(12'h110, 8'h00);
        chk(pad_ctrl[0].oe, 8'h00);
        chk(pad_ctrl[1].oe, 8'h00);
        // multiplexer registers with reserved bits
        for (int i = 0; i < 9; i++)
        begin
            d = 8'(rnd());
            mx[i % 3] = d & msk[i % 3];
            wr(12'(i % 3 * 4), d);
            rdck(12'(i % 3 * 4), mx[i % 3]);
        end
        chk(serial_alt_route, mx[1][0]);
        chk(spi_alt_route, mx[1][2]);
        apb(1'b1, 12'hffc, 8'hff);
        chk(er, 1'b1);
        rdck(12'hffc, 8'h00);
        // port write kinds, each checked against both ports
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 9; k++)
            begin
                d = 8'(rnd());
                wr(pb(p) + 12'(k * 4), d);
                case (k)
                    0: ed[p] = d;
                    1: ed[p] |= d;
                    2: ed[p] &= ~d;
                    3: ed[p] ^= d;
                    4: eo[p] = d;
                    5: eo[p] |= d;
                    6: eo[p] &= ~d;
                    default: eo[p] ^= d;
                endcase
                rdck(pb(p), ed[p]);
                rdck(pb(p) + 12'h010, eo[p]);
                rdck(pb(1 - p), ed[1 - p]);
                chk(pad_ctrl[p].oe, ed[p]);
                chk(pad_ctrl[p].drive, eo[p]);
            end
        for (int p = 0; p < 2; p++)
        begin
            ed[p] = 8'(rnd());
            eo[p] = 8'(rnd());
            wr(12'h200 + 12'(p * 16), ed[p]);
            wr(12'h204 + 12'(p * 16), eo[p]);
            rdck(pb(p), ed[p]);
            rdck(pb(p) + 12'h010, eo[p]);
        end
        // input path in both directions
        for (int i = 0; i < 10; i++)
        begin
            ext <= 16'(rnd());
            tick(3);
            for (int p = 0; p < 2; p++)
            begin
                // odd rounds read the level through the alias window
                ia = i % 2 ? 12'h208 + 12'(p * 16) : pb(p) + 12'h020;
                rdck(ia, lvl(p));
                chk(pin_event[p], lvl(p));
            end
        end
        wr(12'h080, 8'h00);
        ed[0] = 8'h00;
        wr(12'h0c0, 8'h04);
        ext <= 16'h00ff;
        tick(3);
        rdck(12'h0a0, 8'hfe);
        chk(pin_event[0][0], 1'b0);
        // each edge and level sense mode on pin 3, high to low
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h0cc, {5'h00, md[i]});
            tick(3);
            wr(12'h0a4, 8'h08);
            ext <= 16'h00f7;
            tick(5);
            d = (md[i] != SENSE_RISE) ? 8'h08 : 8'h00;
            rdck(12'h0a4, d);
            chk(port_irq, {1'b0, d[3]});
            // in both and rise modes the rising edge is sensed before the mode write lands
            ext <= 16'h00ff;
            wr(12'h0cc, 8'h00);
            rdck(12'h0a4, 8'h08);
            wr(12'h0a4, 8'h08);
            tick(2);
            chk(port_irq, 2'b00);
        end
        wr(12'h0c8, {5'h00, SENSE_LOW});
        tick(1);
        chk(wake_async, 1'b0);
        ext <= 16'h00fb;
        tick(3);
        chk(wake_async, 1'b1);
        // event outputs
        for (int i = 0; i < 4; i++)
        begin
            d = 8'(rnd()) & 8'h03;
            wr(12'h000, d);
            evout_src <= 2'(rnd());
            tick(2);
            chk(evout_oe, d[1:0]);
            chk(evout_pin, evout_src & d[1:0]);
        end
        // timer waveform routing, split and plain
        for (int r = 0; r < 2; r++)
        begin
            wr(12'h008, 8'(r));
            for (int i = 0; i < 8; i++)
            begin
                {timer_split, timer_wave0, timer_low_cmp0} <= 3'(i);
                tick(2);
                src = i[2] ? 8'(i[0]) : 8'(i[1]);
                chk(wave0_alt_pin, r ? src[0] : 1'b0);
                chk(wave0_default_pin, r ? 1'b0 : src[0]);
            end
        end
        wr(12'h140, 8'h88);
        tick(2);
        chk(pad_ctrl[1].pull[0], 1'b1);
        chk(pad_ctrl[1].drive[0], !eo[1][0]);
        summarize();
    end
endmodule // gpio_port_with_pin_mux_tb_top
